// ---- hw/standby_pkg.sv ----
package standby_pkg;
  // idle count at which the chip select is released
  localparam int unsigned idle_clocks = 8;
  // host bus phase clock runs at one quarter of the input clock
  localparam int unsigned phase_divide = 4;
  // level of the released chip select, and reset value of mode select
  localparam logic select_release = 1'b1;
  localparam logic mode_reset = 1'b1;
  // unused strobe cycles the host issues after leaving idle
  localparam int unsigned wake_dummy_cycles = 2;
  // detector kinds
  typedef enum logic [1:0] {
    det_phase_clock = 2'b00,
    det_latch_enable = 2'b01,
    det_static_xnor = 2'b10
  } detect_kind_t;
endpackage

// ---- hw/activity_shifter.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// shift register activity detector
// ------------------------------------------------------------
module activity_shifter #(
  parameter int unsigned depth = standby_pkg::idle_clocks
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  output logic released
);
  logic [depth-1:0] stage;
  logic [depth-1:0] next_stage;

  // shift ones each clock, clear on activity, freeze once full
  always_comb begin
    if (clear) begin
      next_stage = '0;
    end else if (stage[depth-1]) begin
      next_stage = stage;
    end else begin
      next_stage = {stage[depth-2:0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign released = stage[depth-1];

  chk_release_after_depth: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!clear)[*8] |=> released)
    else $error("select not released after eight quiet clocks");

  chk_clear_wakes: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear |=> !released)
    else $error("activity did not reassert select");

  chk_hold_released: assert property (
    @(posedge mclk) disable iff (!rst_n)
    released && !clear |=> released && $stable(stage))
    else $error("released detector changed state");
endmodule // activity_shifter

// ---- hw/bus_idle_standby_detector.sv ----
`timescale 1ns/1ps
// Functional notes
// - select is reasserted before the host's first instruction fetch.
// - bus phase clock normally runs at a quarter of the input clock.
// - after stop the phase clock stays low until an interrupt.
// - at least two phase clock cycles precede the first address strobe.
// - latch enable pulses two clocks in every six or twelve.
// - power control bit 0 enters idle; host clocks keep running.
// - in idle latch enable and program store enable stay high.
// - at least two dummy latch enable cycles follow idle exit.
// - power control bit 1 enters power-down; latch enable held low.
// - static high latch enable releases for idle; static low for power-down.
// - select equals xnor of latch enable and mode bit; the xnor detector releases it after eight matching clocks.
// - the mode bit holds its value while the host sleeps.
// - eight input clocks without phase clock rise release the select.
// - a phase clock rising edge clears the shift register.
// - while stopped ones shift in; resumed activity reasserts select.
module bus_idle_standby_detector #(
  parameter int unsigned depth = standby_pkg::idle_clocks,
  parameter standby_pkg::detect_kind_t kind = standby_pkg::det_phase_clock
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic phase_clock,
  input wire logic latch_enable,
  input wire logic program_store_enable_n,
  input wire logic mode_select_in,
  input wire logic mode_load,
  output logic mode_select,
  output logic chip_select_n,
  output logic standby
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync;
  logic [1:0] next_rst_sync;
  logic rst_n;

  // shift a one in behind the released reset
  always_comb begin
    next_rst_sync = {rst_sync[0], 1'b1};
  end

  // asynchronous assert, two flop release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= next_rst_sync;
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic phase_prev;
  logic latch_prev;
  logic mode_meta;
  logic mode_sync;
  logic mode_in_meta;
  logic mode_in_sync;
  logic [2:0] next_pin_meta;
  logic [2:0] next_pin_sync;
  logic next_phase_prev;
  logic next_latch_prev;
  logic next_mode_meta;
  logic next_mode_sync;
  logic next_mode_in_meta;
  logic next_mode_in_sync;
  logic host_pins_idle;

  // first flop takes the raw pins, second the first, edge flops the second
  always_comb begin
    next_pin_meta = {program_store_enable_n, latch_enable, phase_clock};
    next_pin_sync = pin_meta;
    next_phase_prev = pin_sync[0];
    next_latch_prev = pin_sync[1];
    next_mode_meta = mode_load;
    next_mode_sync = mode_meta;
    next_mode_in_meta = mode_select_in;
    next_mode_in_sync = mode_in_meta;
  end

  // two flops per host pin before any logic reads it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      phase_prev <= 1'b0;
      latch_prev <= 1'b0;
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      mode_in_meta <= 1'b0;
      mode_in_sync <= 1'b0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      phase_prev <= next_phase_prev;
      latch_prev <= next_latch_prev;
      mode_meta <= next_mode_meta;
      mode_sync <= next_mode_sync;
      mode_in_meta <= next_mode_in_meta;
      mode_in_sync <= next_mode_in_sync;
    end
  end

  // both strobes parked high is how the host shows idle
  assign host_pins_idle = pin_sync[1] && pin_sync[2];

  // ------------------------------------------------------------
  // mode select bit
  // ------------------------------------------------------------
  logic mode_reg;
  logic next_mode;

  // mode bit changes only on an explicit load and is held in sleep
  always_comb begin
    next_mode = mode_reg;
    if (mode_sync) begin
      next_mode = mode_in_sync;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= standby_pkg::mode_reset;
    end else begin
      mode_reg <= next_mode;
    end
  end
  assign mode_select = mode_reg;

  // ------------------------------------------------------------
  // activity qualification
  // ------------------------------------------------------------
  logic phase_rise;
  logic latch_edge;
  logic static_match;
  logic clear;

  // phase clock rise is activity while it runs at a quarter rate
  assign phase_rise = pin_sync[0] && !phase_prev;
  // any latch enable change is activity; stops high in idle
  assign latch_edge = pin_sync[1] ^ latch_prev;
  // xnor of latch level and mode bit marks the armed static level
  assign static_match = ~(pin_sync[1] ^ mode_reg);

  always_comb begin
    unique case (kind)
      standby_pkg::det_phase_clock: begin
        clear = phase_rise;
      end
      standby_pkg::det_latch_enable: begin
        clear = latch_edge;
      end
      standby_pkg::det_static_xnor: begin
        clear = !static_match || latch_edge;
      end
      default: begin
        clear = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // quiet period count for the checks
  // ------------------------------------------------------------
  localparam int unsigned quiet_width = $clog2(depth + 3);
  logic [quiet_width-1:0] quiet_count;
  logic [quiet_width-1:0] next_quiet_count;

  // clocks since the last clear, saturating just past the release point
  always_comb begin
    next_quiet_count = quiet_count;
    if (clear) begin
      next_quiet_count = '0;
    end else if (quiet_count != quiet_width'(depth + 2)) begin
      next_quiet_count = quiet_count + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_count <= '0;
    end else begin
      quiet_count <= next_quiet_count;
    end
  end

  // ------------------------------------------------------------
  // detector and select output
  // ------------------------------------------------------------
  logic released;
  logic sel_n;
  logic next_sel_n;

  activity_shifter #(
    .depth(depth)
  ) u_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(clear),
    .released(released)
  );

  // select high puts the peripheral in standby, low wakes it
  always_comb begin
    next_sel_n = released ? standby_pkg::select_release : 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n <= 1'b0;
    end else begin
      sel_n <= next_sel_n;
    end
  end
  assign chip_select_n = sel_n;
  assign standby = sel_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // wake within the dummy cycles the host grants before its fetch
  chk_wake_before_fetch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear |-> ##[1:3] !chip_select_n)
    else $error("select not reasserted after activity");

  chk_quiet_releases: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!clear)[*8] |=> ##1 chip_select_n)
    else $error("select not released after quiet period");

  chk_xnor_mode: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (kind == standby_pkg::det_static_xnor) && !static_match |=> ##1
    !chip_select_n)
    else $error("mismatched latch level did not keep select");

  chk_mode_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !mode_sync |=> $stable(mode_select))
    else $error("mode bit changed without a load");

  chk_mode_load: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mode_sync |=> mode_select == $past(mode_in_sync))
    else $error("mode bit did not take the loaded value");

  chk_standby_mirror: assert property (
    @(posedge mclk) disable iff (!rst_n)
    standby == chip_select_n)
    else $error("standby differs from select");

  chk_select_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    released |=> chip_select_n)
    else $error("select not high after release");

  chk_select_awake: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !released |=> !chip_select_n)
    else $error("select high while detector busy");

  chk_wake_exact: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear |=> ##1 !chip_select_n)
    else $error("select not low two clocks after activity");

  chk_quiet_count: assert property (
    @(posedge mclk) disable iff (!rst_n)
    quiet_count >= quiet_width'(depth + 1) |-> chip_select_n)
    else $error("select low after a full quiet period");

  chk_busy_count: assert property (
    @(posedge mclk) disable iff (!rst_n)
    quiet_count != '0 && quiet_count <= quiet_width'(depth)
    |-> !chip_select_n)
    else $error("select released too early");

  chk_release_count: assert property (
    @(posedge mclk) disable iff (!rst_n)
    released == (quiet_count >= quiet_width'(depth)))
    else $error("release does not match quiet count");

  chk_idle_pins: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (kind == standby_pkg::det_latch_enable) && host_pins_idle
    && latch_prev |-> !clear)
    else $error("parked idle strobes counted as activity");
endmodule // bus_idle_standby_detector

// ---- dv/peripheral_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// peripheral seen through its active-low select
// ------------------------------------------------------------
module peripheral_model (
  input wire logic chip_select_n,
  output logic asleep
);
  // deselected means standby, with no decoding or other function at all
  assign asleep = (chip_select_n === 1'b1);
endmodule // peripheral_model

// ---- dv/test_bus_idle_standby_detector.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench for the bus idle standby detector
// ------------------------------------------------------------
module test_bus_idle_standby_detector;
  logic mclk, resetn, phase_clock, latch_enable, pse_n, mode_in, mode_load;
  logic mode_select, chip_select_n, standby, asleep, run, go;
  logic mode_x, cs_x, standby_x;
  logic [1:0] div;
  int err_count, checked, cycles;

  bus_idle_standby_detector DUT (.mclk(mclk), .resetn(resetn),
    .phase_clock(phase_clock), .latch_enable(latch_enable),
    .program_store_enable_n(pse_n), .mode_select_in(mode_in),
    .mode_load(mode_load), .mode_select(mode_select),
    .chip_select_n(chip_select_n), .standby(standby));
  peripheral_model far_end (.chip_select_n(chip_select_n), .asleep(asleep));
  // same host pins seen by the xnor detector, armed by the mode bit for one sleep level
  bus_idle_standby_detector #(.kind(standby_pkg::det_static_xnor))
    xnor_unit (.mclk(mclk), .resetn(resetn),
    .phase_clock(phase_clock), .latch_enable(latch_enable),
    .program_store_enable_n(pse_n), .mode_select_in(mode_in),
    .mode_load(mode_load), .mode_select(mode_x),
    .chip_select_n(cs_x), .standby(standby_x));

  // free running input clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // host pins: quarter rate phase clock, held static while stopped
  always @(posedge mclk) begin
    go = run;
    #1;
    if (go) begin
      div = div + 2'h1;
      phase_clock = div[1];
      latch_enable = div[1];
      pse_n = div[0];
    end else begin
      phase_clock = 1'b0;
      latch_enable = 1'b1;
      pse_n = 1'b1;
    end
  end

  // cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // wait a bounded number of cycles for the select to reach a level
  task automatic wait_cs(input logic v, input int n);
    int k;
    k = 0;
    while (chip_select_n !== v && k < n) begin
      step(1);
      k++;
    end
  endtask

  task automatic test_running();
    run = 1'b1;
    step(8);
    repeat (10) begin
      step(4);
      check("chip_select_n", chip_select_n, 1'b0);
    end
    $display("test running done");
  endtask

  task automatic test_stop();
    while (div !== 2'h3) step(1);
    run = 1'b0;
    step(6);
    check("chip_select_n early", chip_select_n, 1'b0);
    wait_cs(1'b1, 8);
    check("chip_select_n", chip_select_n, 1'b1);
    check("standby", standby, 1'b1);
    check("asleep", asleep, 1'b1);
    step(20);
    check("chip_select_n held", chip_select_n, 1'b1);
    check("cs_x idle", cs_x, 1'b1);
    check("standby_x", standby_x, 1'b1);
    $display("test stop done");
  endtask

  task automatic test_wake();
    run = 1'b1;
    while (phase_clock !== 1'b1) step(1);
    wait_cs(1'b0, 6);
    check("chip_select_n", chip_select_n, 1'b0);
    check("standby", standby, 1'b0);
    step(8);
    check("chip_select_n awake", chip_select_n, 1'b0);
    check("cs_x awake", cs_x, 1'b0);
    $display("test wake done");
  endtask

  task automatic test_mode();
    check("mode_select reset", mode_select, standby_pkg::mode_reset);
    mode_in = 1'b0;
    mode_load = 1'b1;
    step(4);
    check("mode_select", mode_select, 1'b0);
    mode_load = 1'b0;
    step(3);
    mode_in = 1'b1;
    step(6);
    check("mode_select held", mode_select, 1'b0);
    check("mode_x held", mode_x, 1'b0);
    mode_load = 1'b1;
    step(4);
    check("mode_select", mode_select, 1'b1);
    mode_load = 1'b0;
    $display("test mode done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    run = 1'b0;
    div = 2'h0;
    phase_clock = 1'b0;
    latch_enable = 1'b0;
    pse_n = 1'b1;
    mode_in = 1'b1;
    mode_load = 1'b0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    step(12);
    resetn = 1'b1;
    step(1);
    check("chip_select_n reset", chip_select_n, 1'b0);
    test_mode();
    test_running();
    test_stop();
    test_wake();
    tally_and_finish();
  end
endmodule // test_bus_idle_standby_detector
